// *** design/ssg_cfg.svh ***
// Constants for the shift-skip group execution block
`ifndef SSG_CFG_SVH
`define SSG_CFG_SVH
// Summary of operation
// - Clear T at T0, clear I at T1, load T bits 10-15 into I at T2.
// - I bits 15..10 of 000000 select accumulator A, 000010 select accumulator B.
// - At T4 put accumulator on R bus; set carry when its bit 0 equals T bit 0.
// - Skip test: at T6 load P and M with P plus one plus carry.
// - Left shift moves bits 0-13 up one, keeps bit 15, drops old bit 14.
// - Left shift at T3: accumulator to R bus, left control, T bus back to accumulator.
// - Right shift moves all bits down one, drops bit 0, bit 15 keeps its value.
// - Right shift at T3: T bits 6-9 raise right control and accumulator store.
// - Non-skipping cycles add one to P and M at T6, then set phase 1 or 4.
// - Loop switch blocks the plain P increment; a skip carry still advances P and M by one.
// - Octal 001100 is right shift of A, 005100 right shift of B.
// - Octal 005000 is left shift of B.
// - Group instruction with T bit 5 set clears extend at the T4/T5 boundary.
// - Equal low bits skip the next instruction: P and M advance by two.

// =====================================================
// Register byte offsets
`define SSG_OFF_CTRL 8'h00
`define SSG_OFF_GO 8'h04
`define SSG_OFF_MEM 8'h08
`define SSG_OFF_ACC_A 8'h0C
`define SSG_OFF_ACC_B 8'h10
`define SSG_OFF_PC 8'h14
`define SSG_OFF_STATUS 8'h18
`define SSG_OFF_MADDR 8'h1C

// =====================================================
// Control register fields
`define SSG_CTRL_LOOP 0
`define SSG_CTRL_IRQ 1
`define SSG_CTRL_EXTEND 2

// =====================================================
// Instruction decode
`define SSG_OP_ACC_A 6'h00
`define SSG_OP_ACC_B 6'h02
`define SSG_OP_B_BIT 1
`define SSG_FN_LEFT 4'h8
`define SSG_FN_RIGHT 4'h9
`define SSG_FN_LSB 6
`define SSG_FN_MSB 9
`define SSG_TR_SKIP 3
`define SSG_TR_CLE 5
`define SSG_IR_LSB 10
`define SSG_IR_MSB 15

// =====================================================
// Reset values and step sizes
`define SSG_WORD_RST 16'h0000
`define SSG_IR_RST 6'h00
`define SSG_PC_ONE 16'h0001
`define SSG_PHASE_FETCH 3'h1
`define SSG_PHASE_INT 3'h4
`define SSG_BUS_ZERO 32'h00000000
`endif

// *** design/ssg_dp_if.sv ***
// Datapath signals between the sequencer and the shift unit
`timescale 1ns/1ps
interface ssg_dp_if;
    ssg_pkg::ssg_period_t period;
    logic busy;
    logic [5:0] ir;
    logic [15:0] treg;
    logic [15:0] acc_a;
    logic [15:0] acc_b;
    logic [15:0] rbus;
    logic [15:0] tbus;
    logic shift_group_select;
    logic opcode_zero_decode;
    logic acc_a_to_rbus;
    logic acc_b_to_rbus;
    logic left_shift_magnitude;
    logic right_shift_magnitude;
    logic store_tbus_acc_a;
    logic store_tbus_acc_b;
    logic skip_low_bit_equal;
    logic clear_extend;

    modport seq (
        output period, busy, ir, treg, acc_a, acc_b,
        input rbus, tbus, shift_group_select, opcode_zero_decode, acc_a_to_rbus, acc_b_to_rbus,
        input left_shift_magnitude, right_shift_magnitude, store_tbus_acc_a, store_tbus_acc_b,
        input skip_low_bit_equal, clear_extend
    );
    modport unit (
        input period, busy, ir, treg, acc_a, acc_b,
        output rbus, tbus, shift_group_select, opcode_zero_decode, acc_a_to_rbus, acc_b_to_rbus,
        output left_shift_magnitude, right_shift_magnitude, store_tbus_acc_a, store_tbus_acc_b,
        output skip_low_bit_equal, clear_extend
    );
endinterface

// *** design/ssg_exec.sv ***
// Shift-skip group execution top with APB register access
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "ssg_cfg.svh"
module ssg_exec (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] time_period,
    output logic cycle_busy
);
    // =====================================================
    // State and datapath link
    ssg_pkg::ssg_state_t s;
    ssg_pkg::ssg_state_t next_s;
    ssg_dp_if dp ();

    ssg_shift_unit u_shift (
        .dp (dp.unit)
    );

    // Sequencer view handed to the shift unit
    assign dp.period = s.period;
    assign dp.busy = s.busy;
    assign dp.ir = s.ir;
    assign dp.treg = s.treg;
    assign dp.acc_a = s.acc_a;
    assign dp.acc_b = s.acc_b;

    // Outputs straight from the state flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign time_period = s.period;
    assign cycle_busy = s.busy;

    // =====================================================
    // Bus decode helpers
    logic setup;
    logic access;
    logic mapped;
    logic exec_reg;
    logic [15:0] pc_step;
    logic [15:0] pc_sum;
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && s.pready;
        unique case (paddr)
            `SSG_OFF_CTRL, `SSG_OFF_GO, `SSG_OFF_MEM, `SSG_OFF_ACC_A,
            `SSG_OFF_ACC_B, `SSG_OFF_PC, `SSG_OFF_STATUS, `SSG_OFF_MADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        // Registers the running cycle owns cannot be written mid-cycle
        exec_reg = (paddr == `SSG_OFF_GO) || (paddr == `SSG_OFF_MEM) || (paddr == `SSG_OFF_ACC_A)
            || (paddr == `SSG_OFF_ACC_B) || (paddr == `SSG_OFF_PC);
        // Loop switch blocks only the plain increment; the skip carry still adds
        pc_step = s.loop_switch ? `SSG_WORD_RST : `SSG_PC_ONE;
        pc_sum = s.pc + pc_step + {15'h0000, s.carry_flipflop};
    end

    // =====================================================
    // Next-state logic: bus first, then the timing chain
    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        // Setup cycle: latch answer so the access phase completes with no wait
        if (setup) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !mapped || (pwrite && s.busy && exec_reg);
            next_s.prdata = `SSG_BUS_ZERO;
            if (!pwrite) begin
                unique case (paddr)
                    `SSG_OFF_CTRL: next_s.prdata = {29'h00000000, s.extend, s.irq_pending, s.loop_switch};
                    `SSG_OFF_MEM: next_s.prdata = {16'h0000, s.mem};
                    `SSG_OFF_ACC_A: next_s.prdata = {16'h0000, s.acc_a};
                    `SSG_OFF_ACC_B: next_s.prdata = {16'h0000, s.acc_b};
                    `SSG_OFF_PC: next_s.prdata = {16'h0000, s.pc};
                    `SSG_OFF_MADDR: next_s.prdata = {16'h0000, s.maddr};
                    `SSG_OFF_STATUS: next_s.prdata = {17'h00000, s.phase, s.ir, s.period,
                        s.extend, s.carry_flipflop, s.busy};
                    default: next_s.prdata = `SSG_BUS_ZERO;
                endcase
            end
        end else begin // Outside the answer cycle the bus reads zero
            next_s.pslverr = 1'b0;
            next_s.prdata = `SSG_BUS_ZERO;
        end
        // Access edge with pready high: the write takes effect
        if (access && pwrite && !s.pslverr) begin
            unique case (paddr)
                `SSG_OFF_CTRL: begin
                    next_s.loop_switch = pwdata[`SSG_CTRL_LOOP];
                    next_s.irq_pending = pwdata[`SSG_CTRL_IRQ];
                    next_s.extend = pwdata[`SSG_CTRL_EXTEND];
                end
                `SSG_OFF_GO: begin
                    next_s.busy = 1'b1;
                    next_s.period = ssg_pkg::SSG_T0;
                end
                `SSG_OFF_MEM: next_s.mem = pwdata[15:0];
                `SSG_OFF_ACC_A: next_s.acc_a = pwdata[15:0];
                `SSG_OFF_ACC_B: next_s.acc_b = pwdata[15:0];
                `SSG_OFF_PC: begin
                    next_s.pc = pwdata[15:0];
                    next_s.maddr = pwdata[15:0];
                end
                default: next_s.busy = s.busy;
            endcase
        end
        // One machine cycle of eight periods
        if (s.busy) begin
            next_s.period = ssg_pkg::ssg_period_t'(s.period + 3'h1);
            unique case (s.period)
                ssg_pkg::SSG_T0: begin
                    next_s.treg = `SSG_WORD_RST;
                    next_s.carry_flipflop = 1'b0;
                end
                ssg_pkg::SSG_T1: begin
                    next_s.ir = `SSG_IR_RST;
                    next_s.treg = s.mem;
                end
                ssg_pkg::SSG_T2: begin
                    next_s.ir = s.treg[`SSG_IR_MSB:`SSG_IR_LSB];
                end
                ssg_pkg::SSG_T3: begin
                    // Write-back half of the memory cycle restores the word
                    next_s.mem = s.treg;
                    if (dp.store_tbus_acc_a) begin
                        next_s.acc_a = dp.tbus;
                    end
                    if (dp.store_tbus_acc_b) begin
                        next_s.acc_b = dp.tbus;
                    end
                end
                ssg_pkg::SSG_T4: begin
                    if (dp.skip_low_bit_equal) begin
                        next_s.carry_flipflop = 1'b1;
                    end
                    if (dp.clear_extend) begin
                        next_s.extend = 1'b0;
                    end
                end
                ssg_pkg::SSG_T5: begin
                    next_s.treg = s.treg;
                end
                ssg_pkg::SSG_T6: begin
                    next_s.pc = pc_sum;
                    next_s.maddr = pc_sum;
                end
                ssg_pkg::SSG_T7: begin
                    next_s.phase = s.irq_pending ? `SSG_PHASE_INT : `SSG_PHASE_FETCH;
                    next_s.busy = 1'b0;
                end
            endcase
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '{period: ssg_pkg::SSG_T0, busy: 1'b0, treg: `SSG_WORD_RST, ir: `SSG_IR_RST,
                acc_a: `SSG_WORD_RST, acc_b: `SSG_WORD_RST, pc: `SSG_WORD_RST, maddr: `SSG_WORD_RST,
                mem: `SSG_WORD_RST, carry_flipflop: 1'b0, extend: 1'b0, phase: `SSG_PHASE_FETCH,
                loop_switch: 1'b0, irq_pending: 1'b0, prdata: `SSG_BUS_ZERO, pready: 1'b0,
                pslverr: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // =====================================================
    // Checks beside the logic
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_at_t2;
        s.busy && (s.period == ssg_pkg::SSG_T2);
    endsequence
    sequence s_at_t3;
        s.busy && (s.period == ssg_pkg::SSG_T3);
    endsequence
    sequence s_at_t6;
        s.busy && (s.period == ssg_pkg::SSG_T6);
    endsequence

    ir_load_a: assert property (s_at_t2 |=> s.ir == $past(s.treg[15:10]))
        else $error("instruction register not loaded at T2");
    group_decode_a: assert property (s_at_t3 ##0 (s.ir == `SSG_OP_ACC_B) |-> dp.acc_b_to_rbus && !dp.acc_a_to_rbus)
        else $error("accumulator B not selected");
    carry_set_a: assert property (s.busy && s.period == ssg_pkg::SSG_T4 && s.ir == `SSG_OP_ACC_A
        && s.treg[3] && (s.acc_a[0] == s.treg[0]) |=> s.carry_flipflop ##2 s.carry_flipflop)
        else $error("carry not set on equal low bits");
    skip_pc_a: assert property (s_at_t6 ##0 s.carry_flipflop && !s.loop_switch
        |=> (s.pc == $past(s.pc) + 16'h0002) && (s.maddr == s.pc))
        else $error("skip did not advance by two");
    left_shift_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_A && s.treg[9:6] == `SSG_FN_LEFT
        |=> s.acc_a == {$past(s.acc_a[15]), $past(s.acc_a[13:0]), 1'b0})
        else $error("left shift result wrong");
    right_shift_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_B && s.treg[9:6] == `SSG_FN_RIGHT
        |=> s.acc_b == {$past(s.acc_b[15]), $past(s.acc_b[15:1])})
        else $error("right shift result wrong");
    next_phase_a: assert property (s_at_t6 ##0 !s.carry_flipflop && !s.loop_switch
        |=> (s.pc == $past(s.pc) + 16'h0001) ##1 (!s.busy && s.phase == ($past(s.irq_pending)
        ? `SSG_PHASE_INT : `SSG_PHASE_FETCH)))
        else $error("plain increment or next phase wrong");
    loop_hold_a: assert property (s_at_t6 ##0 s.loop_switch
        |=> s.pc == $past(s.pc) + {15'h0000, $past(s.carry_flipflop)})
        else $error("loop switch did not block increment");
    extend_clr_a: assert property (s.busy && s.period == ssg_pkg::SSG_T4 && s.ir == `SSG_OP_ACC_A && s.treg[5]
        |=> !s.extend)
        else $error("extend not cleared");
    mem_back_a: assert property (s_at_t3 |=> s.mem == $past(s.treg) [*5])
        else $error("memory word not written back");

    // =====================================================
    // Further checks on the timing chain, datapath and bus
    sequence s_at_t0;
        s.busy && (s.period == ssg_pkg::SSG_T0);
    endsequence

    sequence s_at_t1;
        s.busy && (s.period == ssg_pkg::SSG_T1);
    endsequence

    sequence s_at_t4;
        s.busy && (s.period == ssg_pkg::SSG_T4);
    endsequence

    sequence s_at_t7;
        s.busy && (s.period == ssg_pkg::SSG_T7);
    endsequence

    // Fetch half: T cleared, IR cleared, memory word read
    t0_clear_a: assert property (s_at_t0
        |=> s.treg == `SSG_WORD_RST && !s.carry_flipflop)
        else $error("T or carry not cleared");

    t1_load_a: assert property (s_at_t1
        |=> s.ir == `SSG_IR_RST && s.treg == $past(s.mem))
        else $error("T1 clear or read wrong");

    // One period per clock, eight in all, still while idle
    period_step_a: assert property (s.busy && s.period != ssg_pkg::SSG_T7
        |=> s.busy && s.period == $past(s.period) + 3'h1)
        else $error("period did not advance");

    cycle_end_a: assert property (s_at_t7
        |=> !s.busy && s.period == ssg_pkg::SSG_T0)
        else $error("cycle did not end");

    idle_period_a: assert property (!s.busy
        |-> s.period == ssg_pkg::SSG_T0)
        else $error("period moved while idle");

    // Shifts touch only the selected accumulator, and only at T3
    a_right_shift_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_A
        && s.treg[9:6] == `SSG_FN_RIGHT |=> s.acc_a == {$past(s.acc_a[15]), $past(s.acc_a[15:1])})
        else $error("right shift of A wrong");

    b_left_shift_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_B
        && s.treg[9:6] == `SSG_FN_LEFT |=> s.acc_b == {$past(s.acc_b[15]), $past(s.acc_b[13:0]), 1'b0})
        else $error("left shift of B wrong");

    a_kept_a: assert property (s_at_t3 ##0 s.ir != `SSG_OP_ACC_A
        |=> s.acc_a == $past(s.acc_a))
        else $error("A changed unselected");

    b_kept_a: assert property (s_at_t3 ##0 s.ir != `SSG_OP_ACC_B
        |=> s.acc_b == $past(s.acc_b))
        else $error("B changed unselected");

    rbus_source_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_A
        |-> dp.acc_a_to_rbus && dp.rbus == s.acc_a)
        else $error("A not on R bus");

    right_strobe_a: assert property (s_at_t3 ##0 s.ir == `SSG_OP_ACC_A
        && s.treg[9:6] == `SSG_FN_RIGHT |-> dp.right_shift_magnitude && dp.store_tbus_acc_a)
        else $error("right shift strobes missing");

    store_time_a: assert property (dp.store_tbus_acc_a || dp.store_tbus_acc_b
        |-> s_at_t3)
        else $error("store outside T3");

    left_fill_a: assert property (dp.left_shift_magnitude
        |-> !dp.tbus[0] && (dp.tbus[15] == dp.rbus[15]) && (dp.tbus[14] == dp.rbus[13]))
        else $error("left shift fill wrong");

    right_sign_a: assert property (dp.right_shift_magnitude
        |-> (dp.tbus[15] == dp.rbus[15]) && (dp.tbus[14] == dp.rbus[15]) && (dp.tbus[0] == dp.rbus[1]))
        else $error("right shift sign wrong");

    // Skip test sets carry on equal low bits only
    skip_b_a: assert property (s_at_t4 ##0 s.ir == `SSG_OP_ACC_B && s.treg[`SSG_TR_SKIP]
        && (s.acc_b[0] == s.treg[0]) |=> s.carry_flipflop)
        else $error("carry not set for B");

    no_skip_a: assert property (s_at_t4 ##0 s.ir == `SSG_OP_ACC_A && s.treg[`SSG_TR_SKIP]
        && (s.acc_a[0] != s.treg[0]) |=> !s.carry_flipflop)
        else $error("carry set on unequal bits");

    test_bit_a: assert property (s_at_t4 ##0 !s.treg[`SSG_TR_SKIP]
        |=> !s.carry_flipflop)
        else $error("carry set without test");

    // End of cycle: M follows P, next phase chosen
    maddr_follow_a: assert property (s_at_t6
        |=> s.maddr == s.pc)
        else $error("M does not follow P");

    phase_int_a: assert property (s_at_t7 ##0 s.irq_pending
        |=> s.phase == `SSG_PHASE_INT)
        else $error("interrupt phase not set");

    phase_fetch_a: assert property (s_at_t7 ##0 !s.irq_pending
        |=> s.phase == `SSG_PHASE_FETCH)
        else $error("fetch phase not set");

    // Zero-wait answer that stands one cycle; refusal while busy
    ready_next_a: assert property (psel && !penable
        |=> s.pready)
        else $error("no ready after setup");

    ready_pulse_a: assert property (s.pready
        |=> !s.pready)
        else $error("ready held too long");

    ready_low_a: assert property (!s.pready
        |-> s.prdata == `SSG_BUS_ZERO && !s.pslverr)
        else $error("bus answer outside ready");

    write_lands_a: assert property (psel && penable && s.pready && pwrite && !s.pslverr
        && paddr == `SSG_OFF_MEM |=> s.mem == $past(pwdata[15:0]))
        else $error("register write lost");

    busy_refuse_a: assert property (psel && !penable && pwrite && s.busy && paddr == `SSG_OFF_ACC_A
        |=> s.pslverr)
        else $error("busy write not refused");
endmodule

// *** design/ssg_pkg.sv ***
// Types shared by the shift-skip group execution block
package ssg_pkg;
    // Eight time periods of one machine cycle
    typedef enum logic [2:0] {
        SSG_T0 = 3'b000,
        SSG_T1 = 3'b001,
        SSG_T2 = 3'b010,
        SSG_T3 = 3'b011,
        SSG_T4 = 3'b100,
        SSG_T5 = 3'b101,
        SSG_T6 = 3'b110,
        SSG_T7 = 3'b111
    } ssg_period_t;

    // Whole state of the execution top
    typedef struct packed {
        ssg_period_t period;
        logic busy;
        logic [15:0] treg;
        logic [5:0] ir;
        logic [15:0] acc_a;
        logic [15:0] acc_b;
        logic [15:0] pc;
        logic [15:0] maddr;
        logic [15:0] mem;
        logic carry_flipflop;
        logic extend;
        logic [2:0] phase;
        logic loop_switch;
        logic irq_pending;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ssg_state_t;
endpackage

// *** design/ssg_shift_unit.sv ***
// Decode and shifter for the shift-skip group
`timescale 1ns/1ps
`include "ssg_cfg.svh"
module ssg_shift_unit (
    ssg_dp_if.unit dp
);
    // =====================================================
    // Decode, R bus source and shifter
    logic t3;
    logic t4;
    logic sel_b;
    logic [3:0] fn;
    always_comb begin
        t3 = dp.busy && (dp.period == ssg_pkg::SSG_T3);
        t4 = dp.busy && (dp.period == ssg_pkg::SSG_T4);
        sel_b = dp.ir[`SSG_OP_B_BIT];
        fn = dp.treg[`SSG_FN_MSB:`SSG_FN_LSB];
        // Upper four opcode bits zero, then bit 10 low picks the group
        dp.opcode_zero_decode = (dp.ir[5:2] == 4'h0);
        dp.shift_group_select = dp.opcode_zero_decode && !dp.ir[0];
        // Accumulator drives R bus in T3 and T4, as for every group member
        dp.acc_a_to_rbus = dp.shift_group_select && !sel_b && (t3 || t4);
        dp.acc_b_to_rbus = dp.shift_group_select && sel_b && (t3 || t4);
        dp.rbus = dp.acc_a_to_rbus ? dp.acc_a : (dp.acc_b_to_rbus ? dp.acc_b : `SSG_WORD_RST);
        // Only the two arithmetic shifts are decoded; rotates leave accumulators alone
        dp.left_shift_magnitude = dp.shift_group_select && t3 && (fn == `SSG_FN_LEFT);
        dp.right_shift_magnitude = dp.shift_group_select && t3 && (fn == `SSG_FN_RIGHT);
        if (dp.left_shift_magnitude) begin
            dp.tbus = {dp.rbus[15], dp.rbus[13:0], 1'b0};
        end else if (dp.right_shift_magnitude) begin
            dp.tbus = {dp.rbus[15], dp.rbus[15:1]};
        end else begin
            dp.tbus = dp.rbus;
        end
        dp.store_tbus_acc_a = (dp.left_shift_magnitude || dp.right_shift_magnitude) && !sel_b;
        dp.store_tbus_acc_b = (dp.left_shift_magnitude || dp.right_shift_magnitude) && sel_b;
        // Both-zero or both-one counts as equal
        dp.skip_low_bit_equal = dp.shift_group_select && t4 && dp.treg[`SSG_TR_SKIP]
            && (dp.rbus[0] == dp.treg[0]);
        dp.clear_extend = dp.shift_group_select && t4 && dp.treg[`SSG_TR_CLE];
    end
endmodule

// *** sim/ssg_exec_tb.sv ***
// Self-checking bench for the shift-skip group execution top over APB
`timescale 1ns/1ps
`include "ssg_cfg.svh"
module ssg_exec_tb;
    // =====================================================
    // Stimulus and observed signals
    typedef struct packed {
        logic [15:0] mem;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] pc;
        logic [2:0] ctrl;
        logic [15:0] ea;
        logic [15:0] eb;
        logic [15:0] epc;
        logic carry;
        logic [2:0] phase;
        logic [2:0] ectrl;
    } ssg_tb_case_t;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] time_period;
    logic cycle_busy;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int checks_done = 0;

    // Ctrl bits: 0 loop, 1 interrupt pending, 2 extend
    localparam ssg_tb_case_t CASES [12] = '{
        '{16'h0240, 16'h5555, 16'h0000, 16'h0200, 3'h1, 16'h2AAA, 16'h0000, 16'h0200, 1'h0, 3'h1, 3'h1},
        '{16'h0240, 16'h2AAA, 16'h0000, 16'h0200, 3'h1, 16'h1555, 16'h0000, 16'h0200, 1'h0, 3'h1, 3'h1},
        '{16'h0A40, 16'h1234, 16'hD555, 16'h0200, 3'h0, 16'h1234, 16'hEAAA, 16'h0201, 1'h0, 3'h1, 3'h0},
        '{16'h0200, 16'h5555, 16'h0000, 16'h0200, 3'h1, 16'h2AAA, 16'h0000, 16'h0200, 1'h0, 3'h1, 3'h1},
        '{16'h0200, 16'h2AAA, 16'h0000, 16'h0200, 3'h1, 16'h5554, 16'h0000, 16'h0200, 1'h0, 3'h1, 3'h1},
        '{16'h0A00, 16'h0001, 16'hD555, 16'h7FFF, 3'h0, 16'h0001, 16'hAAAA, 16'h8000, 1'h0, 3'h1, 3'h0},
        '{16'h0008, 16'h0000, 16'h0001, 16'h0100, 3'h0, 16'h0000, 16'h0001, 16'h0102, 1'h1, 3'h1, 3'h0},
        '{16'h0008, 16'h0001, 16'h0000, 16'h0100, 3'h0, 16'h0001, 16'h0000, 16'h0101, 1'h0, 3'h1, 3'h0},
        '{16'h0809, 16'h0000, 16'h0001, 16'h0100, 3'h2, 16'h0000, 16'h0001, 16'h0102, 1'h1, 3'h4, 3'h2},
        '{16'h0008, 16'h0000, 16'h0000, 16'h0100, 3'h1, 16'h0000, 16'h0000, 16'h0101, 1'h1, 3'h1, 3'h1},
        '{16'h0020, 16'h5555, 16'h0000, 16'h0100, 3'h4, 16'h5555, 16'h0000, 16'h0101, 1'h0, 3'h1, 3'h0},
        '{16'h1260, 16'h5555, 16'h0000, 16'h0100, 3'h4, 16'h5555, 16'h0000, 16'h0101, 1'h0, 3'h1, 3'h4}
    };

    ssg_exec uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .time_period(time_period),
        .cycle_busy(cycle_busy)
    );

    // Clock at 10 MHz
    always #50 ref_clk = ~ref_clk;

    // =====================================================
    // Compare, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ready and read data are taken at the rising edge; release follows at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        if (n >= 20) begin
            check("pready", 32'h00000001, 32'h00000000);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, rd, er);
        check("pslverr", {31'h0, ee}, {31'h0, er});
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, rd, er);
        check(nm, exp, rd);
    endtask

    // GO, then follow the eight periods one by one
    task automatic go_cycle;
        int n;
        wr(`SSG_OFF_GO, 32'h00000001, 1'b0);
        n = 0;
        @(negedge ref_clk);
        while (cycle_busy === 1'b1 && n < 12) begin
            check("time_period", 32'(n), {29'h0, time_period});
            n++;
            @(negedge ref_clk);
        end
        check("busy cycles", 32'h00000008, 32'(n));
    endtask

    // =====================================================
    // Watchdog, far beyond the expected run length
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end

    // =====================================================
    // Main sequence
    initial begin
        ssg_tb_case_t c;
        int n;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values; phase reads fetch
        rdc("status", `SSG_OFF_STATUS, 32'h00001000);
        rdc("pc", `SSG_OFF_PC, 32'h00000000);
        rdc("acc_a", `SSG_OFF_ACC_A, 32'h00000000);
        // Unmapped address is refused and reads zero
        apb(1'b0, 8'h20, 32'h00000000, rd, er);
        check("unmapped err", 32'h00000001, {31'h0, er});
        check("unmapped data", 32'h00000000, rd);
        // Table of group and non-group instructions
        foreach (CASES[i]) begin
            c = CASES[i];
            wr(`SSG_OFF_CTRL, {29'h0, c.ctrl}, 1'b0);
            wr(`SSG_OFF_MEM, {16'h0, c.mem}, 1'b0);
            wr(`SSG_OFF_ACC_A, {16'h0, c.a}, 1'b0);
            wr(`SSG_OFF_ACC_B, {16'h0, c.b}, 1'b0);
            wr(`SSG_OFF_PC, {16'h0, c.pc}, 1'b0);
            go_cycle();
            rdc("acc_a", `SSG_OFF_ACC_A, {16'h0, c.ea});
            rdc("acc_b", `SSG_OFF_ACC_B, {16'h0, c.eb});
            rdc("pc", `SSG_OFF_PC, {16'h0, c.epc});
            rdc("maddr", `SSG_OFF_MADDR, {16'h0, c.epc});
            rdc("mem", `SSG_OFF_MEM, {16'h0, c.mem});
            rdc("ctrl", `SSG_OFF_CTRL, {29'h0, c.ectrl});
            apb(1'b0, `SSG_OFF_STATUS, 32'h00000000, rd, er);
            check("status", {17'h0, c.phase, c.mem[15:10], 3'h0, c.ectrl[2], c.carry, 1'h0}, rd & 32'h00007FC7);
        end
        // Writes during a running cycle are refused and change nothing
        wr(`SSG_OFF_GO, 32'h00000001, 1'b0);
        wr(`SSG_OFF_ACC_A, 32'h0000FFFF, 1'b1);
        wr(`SSG_OFF_GO, 32'h00000001, 1'b1);
        n = 0;
        while (cycle_busy !== 1'b0 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check("busy end", 32'h00000000, {31'h0, cycle_busy});
        rdc("acc_a kept", `SSG_OFF_ACC_A, 32'h00005555);
        report_and_stop();
    end
endmodule
